/* hdl/ast_pkg.sv */
// Purpose: Constants for the async serial transmitter and receiver.
// Assumes: 8-bit register port, 16 sample ticks per bit.
// Notes:   Register bit positions follow the control/status layout.
// What this block does
// - Length select picks 8 or 9 bits
// - Preamble of ones, then framed data
// - Buffer hand-off sets empty flag, interrupt
// - Enable, read status, write data buffer
// - Idle transmit line is high
// - Module disable releases both pins
// - Send-break keeps loading zero characters
// - Break ends, then at least one 1
// - All-zero frame with zero stop is break
// - Break sets error, full, break flags
// - Idle character all ones, starts transmission
// - Enable toggle queues one idle character
// - Break then idle shortens stop half bit
// - Inversion flips every transmitted level
// - Complete flag when nothing left to send
// - Full character loads buffer, sets full
// - Sixteen-times sampling, resync on edges
// - Start search is zero after three ones
// - Start verify by samples three, five, seven
// - Bits by majority of eight, nine, ten
// - Start bit late ones set noise
// - Framing error set with full flag
// - Overrun keeps old character, drops new
// - Ten or eleven ones set idle flag
package ast_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CTRL1  = 8'h13;
  localparam logic [7:0] ADDR_CTRL2  = 8'h14;
  localparam logic [7:0] ADDR_CTRL3  = 8'h15;
  localparam logic [7:0] ADDR_STAT1  = 8'h16;
  localparam logic [7:0] ADDR_STAT2  = 8'h17;
  localparam logic [7:0] ADDR_DATA   = 8'h18;
  localparam logic [7:0] ADDR_BAUD   = 8'h19;
  // Control one fields
  localparam int C1_ENABLE = 6;
  localparam int C1_INVERT = 5;
  localparam int C1_LEN9   = 4;
  // Control two fields
  localparam int C2_TEIE  = 7;
  localparam int C2_TX_COMPLETE_IRQ_ENABLE  = 6;
  localparam int C2_RFIE  = 5;
  localparam int C2_ILIE  = 4;
  localparam int C2_TXEN  = 3;
  localparam int C2_RXEN  = 2;
  localparam int C2_BREAK = 0;
  // Control three fields
  localparam int C3_RX9 = 7;
  localparam int C3_TX9 = 6;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  // Bit timing in sample ticks
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [4:0] RT_FIRST  = 5'h01;
  localparam logic [4:0] RT_3      = 5'h03;
  localparam logic [4:0] RT_5      = 5'h05;
  localparam logic [4:0] RT_7      = 5'h07;
  localparam logic [4:0] RT_8      = 5'h08;
  localparam logic [4:0] RT_9      = 5'h09;
  localparam logic [4:0] RT_10     = 5'h0a;
  localparam logic [4:0] RT_16     = 5'h10;
  // Frame lengths in bits
  localparam logic [3:0] BITS_8    = 4'ha;
  localparam logic [3:0] BITS_9    = 4'hb;
  localparam logic [3:0] BITS_ONE  = 4'h1;
  localparam logic [3:0] DATA_8    = 4'h8;
  localparam logic [3:0] DATA_9    = 4'h9;
  // Idle detection: ones ticks for 10 or 11 bits
  localparam logic [7:0] IDLE_8    = 8'ha0;
  localparam logic [7:0] IDLE_9    = 8'hb0;

  typedef enum logic [1:0] {
    AST_TK_DATA, AST_TK_BREAK, AST_TK_IDLE, AST_TK_ONE
  } ast_txkind_t;

  typedef enum logic [1:0] {
    AST_RX_HUNT, AST_RX_START, AST_RX_BITS
  } ast_rxstate_t;
endpackage : ast_pkg

/* hdl/ast_serial.sv */
// Purpose: Full-duplex async serial transmitter and receiver.
// Assumes: One 10 MHz core clock, register port on the same clock.
// Notes:   Parity, wakeup and low power are not built; parity reads 0.
//
// Added by the designer: the address map and the address-and-strobe port.
module ast_serial #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_N_I,
  // Register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WR_DATA_I,
  input  wire logic       WR_STB_I,
  input  wire logic       RD_STB_I,
  output logic      [7:0] RD_DATA_O,
  // Baud clock source select
  input  wire logic       BAUD_CLOCK_SOURCE_SELECT_I,
  // Serial pins
  input  wire logic       SERIAL_IN_PIN_I,
  output logic            SERIAL_OUT_PIN_O,
  output logic            SERIAL_OUT_PIN_OE_O,
  output logic            SERIAL_IN_PIN_EN_O,
  // Interrupt requests
  output logic            TX_IRQ_O,
  output logic            RX_IRQ_O
);

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Samples disagree
  function automatic logic mixed3(input logic [2:0] s);
    mixed3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  // Register state
  logic [7:0]       ctrl1_q, ctrl2_q;
  logic             tx9_q, rx9_q;
  logic [7:0]       tx_buf_q, rx_buf_q;
  logic [DIV_W-1:0] baud_q;
  logic             tx_empty_q, rx_full_q, idle_q, ovr_q;
  logic             noise_q, frame_q, brk_q;
  logic             stat_armed_q;
  logic [7:0]       rd_data_q;

  // Decodes
  wire wr_c1   = WR_STB_I && (ADDR_I == ast_pkg::ADDR_CTRL1);
  wire wr_c2   = WR_STB_I && (ADDR_I == ast_pkg::ADDR_CTRL2);
  wire wr_c3   = WR_STB_I && (ADDR_I == ast_pkg::ADDR_CTRL3);
  wire wr_data = WR_STB_I && (ADDR_I == ast_pkg::ADDR_DATA);
  wire wr_baud = WR_STB_I && (ADDR_I == ast_pkg::ADDR_BAUD);
  wire rd_st1  = RD_STB_I && (ADDR_I == ast_pkg::ADDR_STAT1);
  wire rd_data = RD_STB_I && (ADDR_I == ast_pkg::ADDR_DATA);
  wire enable  = ctrl1_q[ast_pkg::C1_ENABLE];
  wire len9    = ctrl1_q[ast_pkg::C1_LEN9];
  wire inv     = ctrl1_q[ast_pkg::C1_INVERT];
  wire tx_en   = enable && ctrl2_q[ast_pkg::C2_TXEN];
  wire rx_en   = enable && ctrl2_q[ast_pkg::C2_RXEN];
  wire send_break     = ctrl2_q[ast_pkg::C2_BREAK];
  wire clr_tx  = wr_data && stat_armed_q;
  wire clr_rx  = rd_data && stat_armed_q;

  // source select picks core rate or half rate
  logic             pre_q;
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  wire src_en  = BAUD_CLOCK_SOURCE_SELECT_I ? pre_q : 1'b1;
  wire div_end = (div_q == baud_q);
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pre_q  <= 1'b0;
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= ~pre_q;
      tick_q <= src_en && div_end && enable;
      if (src_en) begin
        div_q <= div_end ? '0 : div_q + 1'b1;
      end
    end
  end

  // Receive pin synchroniser
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= SERIAL_IN_PIN_I;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Transmitter state
  ast_pkg::ast_txkind_t tx_kind_q;
  logic        tx_busy_q, idle_pend_q, brk_tail_q, te_prev_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_bits_q, tx_tick_q;
  logic        tx_line_q;

  wire [3:0]  frame_len = len9 ? ast_pkg::BITS_9 : ast_pkg::BITS_8;
  // stop at top, start at bottom
  // ninth bit from its own register
  wire [10:0] data_frame = {1'b1, len9 ? tx9_q : 1'b1, tx_buf_q, 1'b0};
  wire bit_end  = tick_q && (tx_tick_q == ast_pkg::TICK_LAST);
  wire last_bit = (tx_bits_q == ast_pkg::BITS_ONE);
  // break followed by idle cuts stop zero short
  wire brk_cut  = tick_q && (tx_kind_q == ast_pkg::AST_TK_BREAK) &&
                  last_bit && (tx_tick_q == ast_pkg::TICK_HALF) &&
                  !send_break && idle_pend_q && tx_empty_q;
  wire char_done = tx_busy_q && ((bit_end && last_bit) || brk_cut);
  wire pick     = tick_q && (!tx_busy_q || char_done);
  wire te_rise  = tx_en && !te_prev_q;
  // Buffer handed to shift register this cycle
  wire load_data = pick && tx_en && !send_break && !idle_pend_q &&
                   !brk_tail_q && !tx_empty_q;

  // enable rise queues one idle char
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      te_prev_q   <= 1'b0;
      idle_pend_q <= 1'b0;
    end else begin
      te_prev_q <= tx_en;
      if (te_rise) begin
        idle_pend_q <= 1'b1;
      end else if (pick && tx_en && !send_break) begin
        idle_pend_q <= 1'b0;
      end
    end
  end

  // Character sequencer; next char chosen only at boundaries
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_busy_q  <= 1'b0;
      tx_kind_q  <= ast_pkg::AST_TK_IDLE;
      tx_sh_q    <= '1;
      tx_bits_q  <= '0;
      tx_tick_q  <= '0;
      brk_tail_q <= 1'b0;
    end else if (!enable) begin
      tx_busy_q  <= 1'b0;
      brk_tail_q <= 1'b0;
      tx_tick_q  <= '0;
    end else if (pick) begin
      tx_tick_q <= '0;
      tx_bits_q <= frame_len;
      tx_busy_q <= tx_en;
      if (!tx_en) begin
        // line idles once current char ends
        tx_sh_q <= '1;
      end else if (send_break) begin
        // break chars while send-break is set
        tx_kind_q  <= ast_pkg::AST_TK_BREAK;
        tx_sh_q    <= '0;
        brk_tail_q <= 1'b1;
      end else if (idle_pend_q) begin
        tx_kind_q  <= ast_pkg::AST_TK_IDLE;
        tx_sh_q    <= '1;
        brk_tail_q <= 1'b0;
      end else if (brk_tail_q) begin
        tx_kind_q  <= ast_pkg::AST_TK_ONE;
        tx_sh_q    <= '1;
        tx_bits_q  <= ast_pkg::BITS_ONE;
        brk_tail_q <= 1'b0;
      end else if (!tx_empty_q) begin
        tx_kind_q <= ast_pkg::AST_TK_DATA;
        tx_sh_q   <= data_frame;
      end else begin
        tx_busy_q <= 1'b0;
      end
    end else if (tick_q && tx_busy_q) begin
      tx_tick_q <= tx_tick_q + 1'b1;
      if (bit_end) begin
        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 1'b1;
      end
    end
  end

  // idle level high when not shifting
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_line_q <= 1'b1;
    end else begin
      tx_line_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
    end
  end

  wire tx_done = tx_empty_q && !tx_busy_q && !idle_pend_q &&
                 !brk_tail_q && !(tx_en && send_break);

  // Receiver state
  ast_pkg::ast_rxstate_t rx_st_q;
  logic [4:0] rt_q;
  logic [2:0] hist_q, smp_q;
  logic [3:0] rx_bitn_q;
  logic [8:0] rx_sh_q;
  logic       rx_noise_q, last_one_q, rx_prev_q;
  logic [7:0] ones_q;
  logic       idle_arm_q;

  wire [3:0] data_len = len9 ? ast_pkg::DATA_9 : ast_pkg::DATA_8;
  wire rx_bit   = rx_s2_q;
  wire start_hit = (hist_q == 3'b111) && !rx_bit;
  wire at_sample = (rt_q == ast_pkg::RT_8) || (rt_q == ast_pkg::RT_9) ||
                   (rt_q == ast_pkg::RT_10);
  wire [2:0] smp_n = {smp_q[1:0], rx_bit};
  wire bit_val  = maj3(smp_n);
  wire decide   = tick_q && (rt_q == ast_pkg::RT_10);
  wire stop_now = (rx_bitn_q == data_len);
  // zero data with zero stop is break
  wire is_break = (len9 ? (rx_sh_q == '0) : (rx_sh_q[8:1] == '0)) &&
                  !bit_val;
  wire rx_fin   = (rx_st_q == ast_pkg::AST_RX_BITS) && decide && stop_now;
  wire [7:0] rx_byte = len9 ? rx_sh_q[7:0] : rx_sh_q[8:1];
  wire       rx_top  = len9 ? rx_sh_q[8] : rx_sh_q[8];
  wire rx_store = rx_fin && !rx_full_q;
  wire rx_ovr   = rx_fin && rx_full_q;
  wire frame_err = rx_fin && !bit_val;
  wire rx_mixed  = (rx_st_q == ast_pkg::AST_RX_BITS) && decide &&
                   mixed3(smp_n);

  // Sample clock counter and receive sequencer
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_st_q    <= ast_pkg::AST_RX_HUNT;
      rt_q       <= '0;
      hist_q     <= '0;
      smp_q      <= '0;
      rx_bitn_q  <= '0;
      rx_sh_q    <= '0;
      rx_noise_q <= 1'b0;
      last_one_q <= 1'b0;
      rx_prev_q  <= 1'b1;
    end else if (!rx_en) begin
      rx_st_q <= ast_pkg::AST_RX_HUNT;
      hist_q  <= '0;
    end else if (tick_q) begin
      rx_prev_q <= rx_bit;
      rt_q      <= (rt_q == ast_pkg::RT_16) ? ast_pkg::RT_FIRST
                                            : rt_q + 1'b1;
      if (at_sample || rt_q == ast_pkg::RT_3 || rt_q == ast_pkg::RT_5 ||
          rt_q == ast_pkg::RT_7) begin
        smp_q <= smp_n;
      end
      unique case (rx_st_q)
        ast_pkg::AST_RX_HUNT: begin
          hist_q <= {hist_q[1:0], rx_bit};
          if (start_hit) begin
            rx_st_q    <= ast_pkg::AST_RX_START;
            rt_q       <= ast_pkg::RT_FIRST;
            rx_noise_q <= 1'b0;
          end
        end
        ast_pkg::AST_RX_START: begin
          if (rt_q == ast_pkg::RT_7) begin
            if (bit_val) begin
              rx_st_q <= ast_pkg::AST_RX_HUNT;
              hist_q  <= '0;
            end else begin
              rx_noise_q <= mixed3(smp_n);
            end
          end
          // late start ones flag noise only
          if (at_sample && rx_bit) begin
            rx_noise_q <= 1'b1;
          end
          if (rt_q == ast_pkg::RT_16) begin
            rx_st_q    <= ast_pkg::AST_RX_BITS;
            rx_bitn_q  <= '0;
            last_one_q <= 1'b0;
          end
        end
        ast_pkg::AST_RX_BITS: begin
          // resync on edge after a one
          if (last_one_q && rx_prev_q && !rx_bit &&
              (rt_q > ast_pkg::RT_10 || rt_q < ast_pkg::RT_8)) begin
            rt_q <= ast_pkg::RT_FIRST;
          end
          if (decide) begin
            if (mixed3(smp_n)) begin
              rx_noise_q <= 1'b1;
            end
            last_one_q <= bit_val;
            if (stop_now) begin
              rx_st_q <= ast_pkg::AST_RX_HUNT;
              hist_q  <= {3{bit_val}};
            end else begin
              rx_sh_q   <= {bit_val, rx_sh_q[8:1]};
              rx_bitn_q <= rx_bitn_q + 1'b1;
            end
          end
        end
        default: begin
          rx_st_q <= ast_pkg::AST_RX_HUNT;
        end
      endcase
    end
  end

  // count line ones for 10 or 11 bit times
  wire [7:0] idle_len = len9 ? ast_pkg::IDLE_9 : ast_pkg::IDLE_8;
  wire idle_hit = tick_q && idle_arm_q && (ones_q == idle_len);
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ones_q     <= '0;
      idle_arm_q <= 1'b0;
    end else if (tick_q) begin
      if (!rx_bit || !rx_en) begin
        ones_q     <= '0;
        idle_arm_q <= rx_en;
      end else if (ones_q != idle_len) begin
        ones_q <= ones_q + 1'b1;
      end else begin
        idle_arm_q <= 1'b0;
      end
    end
  end

  // Control registers; ninth receive bit written by hardware only
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl1_q <= ast_pkg::RST_ZERO;
      ctrl2_q <= ast_pkg::RST_ZERO;
      tx9_q   <= 1'b0;
      baud_q  <= DIV_W'(ast_pkg::RST_BAUD);
    end else begin
      if (wr_c1) ctrl1_q <= WR_DATA_I;
      if (wr_c2) ctrl2_q <= WR_DATA_I;
      if (wr_c3) tx9_q <= WR_DATA_I[ast_pkg::C3_TX9];
      if (wr_baud) baud_q <= DIV_W'(WR_DATA_I);
    end
  end

  // Data buffers; buffer contents cleared by reset, the value has no meaning
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_buf_q <= '0;
      rx_buf_q <= '0;
      rx9_q    <= 1'b0;
    end else begin
      if (wr_data) tx_buf_q <= WR_DATA_I;
      // break clears buffer and ninth bit
      if (rx_store) begin
        rx_buf_q <= is_break ? 8'h00 : rx_byte;
        rx9_q    <= is_break ? 1'b0 : rx_top;
      end
    end
  end

  // Status flags; a set in the clear cycle wins
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_empty_q   <= 1'b1;
      rx_full_q    <= 1'b0;
      idle_q       <= 1'b0;
      ovr_q        <= 1'b0;
      noise_q      <= 1'b0;
      frame_q      <= 1'b0;
      brk_q        <= 1'b0;
      stat_armed_q <= 1'b0;
    end else begin
      if (rd_st1) stat_armed_q <= 1'b1;
      else if (rd_data || wr_data) stat_armed_q <= 1'b0;
      if (clr_tx) tx_empty_q <= 1'b0;
      if (load_data) tx_empty_q <= 1'b1;
      if (clr_rx) begin
        rx_full_q <= 1'b0;
        idle_q    <= 1'b0;
        ovr_q     <= 1'b0;
        noise_q   <= 1'b0;
        frame_q   <= 1'b0;
        brk_q     <= 1'b0;
      end
      if (rx_store) rx_full_q <= 1'b1;
      if (frame_err) frame_q <= 1'b1;
      if (rx_fin && is_break) brk_q <= 1'b1;
      if (rx_ovr) ovr_q <= 1'b1;
      if (rx_fin && (rx_noise_q || rx_mixed)) noise_q <= 1'b1;
      if (idle_hit) idle_q <= 1'b1;
    end
  end

  // Read mux, registered for next-cycle data
  logic [7:0] rd_mux;
  always_comb begin
    unique case (ADDR_I)
      ast_pkg::ADDR_CTRL1: rd_mux = ctrl1_q;
      ast_pkg::ADDR_CTRL2: rd_mux = ctrl2_q;
      ast_pkg::ADDR_CTRL3: rd_mux = {rx9_q, tx9_q, 6'h00};
      ast_pkg::ADDR_STAT1: rd_mux = {tx_empty_q, tx_done, rx_full_q,
                                     idle_q, ovr_q, noise_q, frame_q,
                                     1'b0};
      ast_pkg::ADDR_STAT2: rd_mux = {6'h00, brk_q,
                                     rx_st_q != ast_pkg::AST_RX_HUNT};
      ast_pkg::ADDR_DATA:  rd_mux = rx_buf_q;
      ast_pkg::ADDR_BAUD:  rd_mux = 8'(baud_q);
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= RD_STB_I ? rd_mux : 8'h00;
    end
  end

  // Pin and interrupt outputs, all registered
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SERIAL_OUT_PIN_O    <= 1'b1;
      SERIAL_OUT_PIN_OE_O <= 1'b0;
      SERIAL_IN_PIN_EN_O  <= 1'b0;
      TX_IRQ_O            <= 1'b0;
      RX_IRQ_O            <= 1'b0;
    end else begin
      SERIAL_OUT_PIN_O    <= tx_line_q ^ inv;
      SERIAL_OUT_PIN_OE_O <= enable;
      SERIAL_IN_PIN_EN_O  <= enable;
      // complete flag gated by its enable
      TX_IRQ_O <= (tx_empty_q && ctrl2_q[ast_pkg::C2_TEIE]) ||
                  (tx_done && ctrl2_q[ast_pkg::C2_TX_COMPLETE_IRQ_ENABLE]);
      // idle flag gated by its enable
      RX_IRQ_O <= (rx_full_q && ctrl2_q[ast_pkg::C2_RFIE]) ||
                  (idle_q && ctrl2_q[ast_pkg::C2_ILIE]);
    end
  end

  // Read data straight from its register
  assign RD_DATA_O = rd_data_q;

endmodule : ast_serial

/* tb/ast_serial_props.sv */
// Purpose: Port checks for the serial block
// Assumes: Baud divisor 0 and core-rate source
// Notes:   Cycle counts below hold at that rate only
module ast_serial_props (
  // Clock, reset, register port
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_N_I,
  input wire logic       WR_STB_I,
  input wire logic       RD_STB_I,
  input wire logic [7:0] RD_DATA_O,
  // Pins and requests
  input wire logic       SERIAL_OUT_PIN_O,
  input wire logic       SERIAL_OUT_PIN_OE_O,
  input wire logic       SERIAL_IN_PIN_EN_O,
  input wire logic       TX_IRQ_O,
  input wire logic       RX_IRQ_O
);
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Both pins are claimed and released together
  a_pins_paired: assert property (
    SERIAL_OUT_PIN_OE_O == SERIAL_IN_PIN_EN_O) else $error("pins split");
  // Only software moves the module enable
  a_claim_by_write: assert property (
    $changed(SERIAL_OUT_PIN_OE_O) |-> $past(WR_STB_I) ||
    $past(WR_STB_I, 2) || $past(WR_STB_I, 3)) else $error("claim moved");
  // A released line does not wiggle
  a_off_quiet: assert property (
    !SERIAL_OUT_PIN_OE_O [*4] |-> $stable(SERIAL_OUT_PIN_O))
    else $error("released line moved");
  // Read data only in the slot after a read strobe
  a_read_slot: assert property (
    !$past(RD_STB_I) |-> RD_DATA_O == 8'h00) else $error("stray data");
  // No level is shorter than half a bit, even a cut break stop
  a_half_bit_min: assert property (
    $changed(SERIAL_OUT_PIN_O) |=> $stable(SERIAL_OUT_PIN_O) [*7])
    else $error("short level");
  // Every start follows at least one full bit of ones
  a_mark_first: assert property (
    $fell(SERIAL_OUT_PIN_O) |-> $past(SERIAL_OUT_PIN_O, 16))
    else $error("start too soon");
  // Receive request drops only after software touches the block
  a_rx_irq_drop: assert property (
    $fell(RX_IRQ_O) |-> $past(RD_STB_I) || $past(RD_STB_I, 2) ||
    $past(RD_STB_I, 3) || $past(WR_STB_I) || $past(WR_STB_I, 2) ||
    $past(WR_STB_I, 3)) else $error("rx request lost");
  // Transmit request drops only after a register write
  a_tx_irq_drop: assert property (
    $fell(TX_IRQ_O) |-> $past(WR_STB_I) || $past(WR_STB_I, 2) ||
    $past(WR_STB_I, 3)) else $error("tx request lost");
  // Main scenarios reached
  c_tx_frame: cover property ($fell(SERIAL_OUT_PIN_O));
  c_rx_char: cover property ($rose(RX_IRQ_O));
  c_tx_req: cover property ($rose(TX_IRQ_O));
endmodule // ast_serial_props

bind ast_serial ast_serial_props u_ast_serial_props (
  .CORE_CLK_I, .RESET_N_I, .WR_STB_I, .RD_STB_I, .RD_DATA_O,
  .SERIAL_OUT_PIN_O, .SERIAL_OUT_PIN_OE_O, .SERIAL_IN_PIN_EN_O,
  .TX_IRQ_O, .RX_IRQ_O);

/* tb/ast_remote.sv */
// Purpose: Far-side serial device: sends frames, decodes what it hears
// Assumes: One bit is 16 core cycles
// Notes:   Behavioural; the line idles high like a pulled-up mark
module ast_remote (
  // Clock and length select
  input  wire logic clk_i,
  input  wire logic len9_i,
  // Serial lines
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got_q;
  logic       stop_q;
  int         cnt_q = 0;

  // Mid-bit decode; rearms only once the line is high again
  initial begin
    rxd_o = 1'h1;
    forever begin
      wait (txd_i === 1'h1);
      @(negedge txd_i);
      repeat (8) @(posedge clk_i);
      got_q = 9'h000;
      for (int i = 0; i <= 8 + int'(len9_i); i++) begin
        repeat (16) @(posedge clk_i);
        if (i == 8 + int'(len9_i)) stop_q = txd_i;
        else got_q[i] = txd_i;
      end
      cnt_q++;
    end
  end

  // One frame: start, data LSB first, then the given stop level
  task automatic send(input logic [8:0] d, input int nb, input logic stop,
                      input int glitch);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'h0 : (i == nb + 1) ? stop : d[i - 1];
      for (int t = 0; t < 16; t++) begin
        @(posedge clk_i);
        // one-tick glitch on the middle sample
        rxd_o <= (i == glitch && t == 9) ? ~b : b;
      end
    end
    @(posedge clk_i);
    rxd_o <= 1'h1;
  endtask
endmodule // ast_remote

/* tb/tb_async_serial_tx_rx.sv */
// Purpose: Self-checking bench for the serial block
// Assumes: Baud divisor left at 0, so one bit is 16 core cycles
// Notes:   Rows cover receive, break and framing error; other cases are hand-written
module tb_async_serial_tx_rx;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: byte sent, its stop level, status one and two expected
  typedef struct packed {
    logic [7:0] d;
    logic       s;
    logic [7:0] s1;
    logic [7:0] s2;
  } ast_row_t;
  ast_row_t   rows [4] = '{
    '{8'h55, 1'h1, 8'h20, 8'h00}, '{8'h80, 1'h1, 8'h20, 8'h00},
    '{8'h00, 1'h0, 8'h22, 8'h02}, '{8'h3c, 1'h0, 8'h22, 8'h00}};
  logic       clk, rst_n, wr_stb, rd_stb, len9, sin, sout, oe, ien;
  logic       tx_irq, rx_irq;
  logic [7:0] addr, wdata, rdata;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  ast_serial u_ast_serial (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WR_DATA_I(wdata), .WR_STB_I(wr_stb), .RD_STB_I(rd_stb),
    .RD_DATA_O(rdata), .BAUD_CLOCK_SOURCE_SELECT_I(1'h0),
    .SERIAL_IN_PIN_I(sin), .SERIAL_OUT_PIN_O(sout),
    .SERIAL_OUT_PIN_OE_O(oe), .SERIAL_IN_PIN_EN_O(ien),
    .TX_IRQ_O(tx_irq), .RX_IRQ_O(rx_irq));
  ast_remote u_ast_remote (
    .clk_i(clk), .len9_i(len9), .txd_i(sout), .rxd_o(sin));

  // 10 MHz core clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Hang guard; the run needs about an eighth of this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [8:0] e, s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  // Register port cycles, one strobe each
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a, m, e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1 chk(n, {1'h0, e}, {1'h0, rdata & m});
  endtask

  // Bounded wait for the far side to decode one character
  task automatic txw();
    int n;
    n = u_ast_remote.cnt_q;
    for (int k = 0; k < 600 && u_ast_remote.cnt_q == n; k++)
      @(posedge clk);
    chk("tx_seen", 9'h001, {8'h00, u_ast_remote.cnt_q != n});
  endtask

  initial begin
    {rst_n, wr_stb, rd_stb, len9} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values and an unmapped place
    rdc("stat1", ast_pkg::ADDR_STAT1, 8'hff, 8'hc0);
    rdc("ctrl2", ast_pkg::ADDR_CTRL2, 8'hff, 8'h00);
    rdc("unmapped", 8'h20, 8'hff, 8'h00);
    wr(ast_pkg::ADDR_CTRL1, 8'h40);
    wr(ast_pkg::ADDR_CTRL2, 8'h2c);
    repeat (4) @(posedge clk);
    chk("oe", 9'h001, {8'h00, oe});
    $display("reset and enable done");
    // Plain receive rows, break among them
    foreach (rows[i]) begin
      u_ast_remote.send({1'h0, rows[i].d}, 8, rows[i].s, -1);
      repeat (20) @(posedge clk);
      chk("rx_irq", 9'h001, {8'h00, rx_irq});
      rdc("stat1", ast_pkg::ADDR_STAT1, 8'h27, rows[i].s1);
      rdc("stat2", ast_pkg::ADDR_STAT2, 8'h02, rows[i].s2);
      rdc("ninth", ast_pkg::ADDR_CTRL3, 8'h80,
          {rows[i].d[7] & rows[i].s, 7'h00});
      rdc("data", ast_pkg::ADDR_DATA, 8'hff, rows[i].d);
      $display("rx row %0d done", i);
    end
    // Overrun keeps the first character
    u_ast_remote.send(9'h011, 8, 1'h1, -1);
    u_ast_remote.send(9'h022, 8, 1'h1, -1);
    repeat (20) @(posedge clk);
    rdc("overrun", ast_pkg::ADDR_STAT1, 8'h28, 8'h28);
    rdc("kept", ast_pkg::ADDR_DATA, 8'hff, 8'h11);
    // One noisy sample does not change the bit
    u_ast_remote.send(9'h00f, 8, 1'h1, 3);
    repeat (20) @(posedge clk);
    rdc("noise", ast_pkg::ADDR_STAT1, 8'h26, 8'h24);
    rdc("noisy", ast_pkg::ADDR_DATA, 8'hff, 8'h0f);
    $display("overrun and noise done");
    // Transmit an 8-bit character with the empty request on
    wr(ast_pkg::ADDR_CTRL2, 8'hac);
    rdc("empty", ast_pkg::ADDR_STAT1, 8'h80, 8'h80);
    wr(ast_pkg::ADDR_DATA, 8'h5a);
    txw();
    chk("tx_char", 9'h05a, u_ast_remote.got_q);
    chk("tx_stop", 9'h001, {8'h00, u_ast_remote.stop_q});
    chk("tx_irq", 9'h001, {8'h00, tx_irq});
    // Nine-bit characters both ways
    wr(ast_pkg::ADDR_CTRL1, 8'h50);
    len9 <= 1'h1;
    wr(ast_pkg::ADDR_CTRL3, 8'h40);
    rdc("empty9", ast_pkg::ADDR_STAT1, 8'h80, 8'h80);
    wr(ast_pkg::ADDR_DATA, 8'h33);
    txw();
    chk("tx_ninth", 9'h133, u_ast_remote.got_q);
    u_ast_remote.send(9'h1aa, 9, 1'h1, -1);
    repeat (20) @(posedge clk);
    rdc("full9", ast_pkg::ADDR_STAT1, 8'h20, 8'h20);
    rdc("rx_ninth", ast_pkg::ADDR_CTRL3, 8'h80, 8'h80);
    rdc("data9", ast_pkg::ADDR_DATA, 8'hff, 8'haa);
    wr(ast_pkg::ADDR_CTRL1, 8'h40);
    len9 <= 1'h0;
    $display("transmit and nine-bit done");
    // Break characters, then a character after the mark
    wr(ast_pkg::ADDR_CTRL2, 8'had);
    txw();
    chk("brk_char", 9'h000, u_ast_remote.got_q);
    chk("brk_stop", 9'h000, {8'h00, u_ast_remote.stop_q});
    wr(ast_pkg::ADDR_CTRL2, 8'hac);
    repeat (200) @(posedge clk);
    rdc("empty_b", ast_pkg::ADDR_STAT1, 8'h80, 8'h80);
    wr(ast_pkg::ADDR_DATA, 8'h81);
    txw();
    chk("after_brk", 9'h081, u_ast_remote.got_q);
    $display("break done");
    // Inverted idle level with the transmitter off
    wr(ast_pkg::ADDR_CTRL2, 8'h24);
    repeat (40) @(posedge clk);
    wr(ast_pkg::ADDR_CTRL1, 8'h60);
    repeat (8) @(posedge clk);
    chk("inv_idle", 9'h000, {8'h00, sout});
    wr(ast_pkg::ADDR_CTRL1, 8'h40);
    repeat (20) @(posedge clk);
    // Module disable lets go of both pins
    wr(ast_pkg::ADDR_CTRL1, 8'h00);
    repeat (8) @(posedge clk);
    chk("oe_off", 9'h000, {8'h00, oe});
    chk("in_off", 9'h000, {8'h00, ien});
    $display("invert and disable done");
    summarize();
  end
endmodule // tb_async_serial_tx_rx
